// [cdpm_pkg.sv]
// constants and types for the port c/d pin function multiplexer
package cdpm_pkg;
	// pin indices inside the shared pin vector
	localparam int NPINS = 12;
	localparam int PIN_C12 = 0;
	localparam int PIN_C15 = 3;
	localparam int PIN_D4 = 4;
	localparam int PIN_D5 = 5;
	localparam int PIN_D7 = 7;
	localparam int PIN_TDI = 8;
	localparam int PIN_TDO = 9;
	localparam int PIN_TCK = 10;
	localparam int PIN_TMS = 11;
	// function select codes, two bits per pin
	localparam int FNW = 2;
	localparam logic [1:0] FN_GPIO = 2'h0;
	localparam logic [1:0] FN_ALT1 = 2'h1;
	localparam logic [1:0] FN_TEST = 2'h1;
	localparam logic [1:0] FN_ALT2 = 2'h2;
	// reset values: port pins general purpose, test pins in test function
	localparam logic [23:0] FUNC_RST = 24'h550000;
	localparam logic [11:0] DIR_RST = 12'h000;
	// instruction register of the test port
	localparam int IR_W = 4;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	localparam logic [3:0] IR_RST = 4'hF;
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR,
		TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
		TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} cdpm_tap_t;
endpackage

// [cdpm_pin_cell.sv]
// one pad driver: chooses between general purpose and alternate drive
`timescale 1ns/1ps
module cdpm_pin_cell
	import cdpm_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [1:0] func_in,
	input wire logic dir_in,
	input wire logic gpio_data_in,
	input wire logic alt_drive_in,
	input wire logic alt_data_in,
	output logic pad_out,
	output logic pad_oe_n_out
);
	logic pad_nxt;
	logic oe_n_nxt;

	// driver choice; alternate functions disconnect the port driver
	always_comb
	begin
		if (func_in == FN_GPIO)
		begin
			pad_nxt = gpio_data_in;
			oe_n_nxt = ~dir_in;
		end
		else
		begin
			pad_nxt = alt_data_in;
			oe_n_nxt = ~alt_drive_in;
		end
	end

	// register the pad drive, released after reset
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			pad_out <= 1'b0;
			pad_oe_n_out <= 1'b1;
		end
		else
		begin
			pad_out <= pad_nxt;
			pad_oe_n_out <= oe_n_nxt;
		end
	end
endmodule

// [cdpm_top.sv]
// port c/d pin function multiplexer with test port pin timing
//
// Behaviour
// - each general purpose pin has own direction
// - upper port c pins reset to general purpose
// - port d pins four to seven reset general
// - crystal output pin can be external clock
// - test pins reset to test function
// - test data sampled on test clock rise
// - test output driven only shifting, falling edge
// - mode select sampled on test clock rise
// - test clock steps test logic; clock pin leaving test function resets it
`timescale 1ns/1ps
module cdpm_top
	import cdpm_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic cfg_load_in,
	input wire logic [23:0] func_sel_in,
	input wire logic [11:0] dir_sel_in,
	input wire logic [11:0] gpio_data_in,
	input wire logic [11:0] pad_in,
	output logic [11:0] pad_out,
	output logic [11:0] pad_oe_n_out,
	output logic [11:0] gpio_read_out,
	output logic [11:0] analog_en_out,
	output logic [23:0] func_out,
	output logic serial1_rx_data_out,
	output logic ext_clock_out,
	output logic [3:0] tap_ir_out,
	output logic tap_reset_out
);
	// config state
	logic [23:0] func_r, func_nxt;
	logic [11:0] dir_r, dir_nxt;
	logic loaded_r, loaded_nxt;
	logic [11:0] analog_r, analog_nxt;
	logic rx_r, rx_nxt;
	logic clk_sel_r, clk_sel_nxt;
	// pad synchronisers and stable values
	logic [11:0] s1_r, s2_r, s3_r, st_r, st_nxt;
	// test port state
	cdpm_tap_t tap_st_r, tap_st_nxt;
	logic [3:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
	logic byp_r, byp_nxt, tap_rst_r, tap_rst_nxt;
	logic tdo_r, tdo_nxt, tdo_en_r, tdo_en_nxt;
	logic tap_on, tck_rise, tck_fall, tms_v, tdi_v;

	// function code of one pin
	function automatic logic [1:0] fn_of(input logic [23:0] v, input int i);
		fn_of = v[i*FNW +: FNW];
	endfunction

	// pin is connected to an analog switch
	function automatic logic is_analog(input logic [23:0] v, input int i);
		is_analog = (i <= PIN_D7) && (fn_of(v, i) == FN_ALT1);
	endfunction

	// next config: loaded on strobe, outputs derived from pins
	always_comb
	begin
		func_nxt = func_r;
		dir_nxt = dir_r;
		loaded_nxt = loaded_r | cfg_load_in;
		if (cfg_load_in)
		begin
			func_nxt = func_sel_in;
			dir_nxt = dir_sel_in;
		end
		for (int i = 0; i < NPINS; i++)
		begin
			analog_nxt[i] = is_analog(func_r, i);
		end
		rx_nxt = (fn_of(func_r, PIN_C12) == FN_ALT2) ? st_r[PIN_C12] : 1'b1;
		// external clock taken from crystal output pin
		clk_sel_nxt = (fn_of(func_r, PIN_D5) == FN_ALT2) & st_r[PIN_D5];
	end

	// config registers; reset gives general purpose ports, test pins
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			func_r <= FUNC_RST;
			dir_r <= DIR_RST;
			loaded_r <= 1'b0;
			analog_r <= 12'h000;
			rx_r <= 1'b1;
			clk_sel_r <= 1'b0;
		end
		else
		begin
			func_r <= func_nxt;
			dir_r <= dir_nxt;
			loaded_r <= loaded_nxt;
			analog_r <= analog_nxt;
			rx_r <= rx_nxt;
			clk_sel_r <= clk_sel_nxt;
		end
	end

	// three stage pad sync; value accepted when stages two and three agree
	always_comb
	begin
		for (int i = 0; i < NPINS; i++)
		begin
			st_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : st_r[i];
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s1_r <= 12'h000;
			s2_r <= 12'h000;
			s3_r <= 12'h000;
			st_r <= 12'h000;
		end
		else
		begin
			s1_r <= pad_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			st_r <= st_nxt;
		end
	end

	// test clock edges step the test logic; outside test function it is held in reset
	assign tap_on = (fn_of(func_r, PIN_TCK) == FN_TEST);
	assign tck_rise = tap_on & s2_r[PIN_TCK] & s3_r[PIN_TCK] & ~st_r[PIN_TCK];
	assign tck_fall = tap_on & ~s2_r[PIN_TCK] & ~s3_r[PIN_TCK] & st_r[PIN_TCK];
	// pins taken for port use read as pulled high
	assign tms_v = (fn_of(func_r, PIN_TMS) == FN_TEST) ? st_r[PIN_TMS] : 1'b1;
	assign tdi_v = (fn_of(func_r, PIN_TDI) == FN_TEST) ? st_r[PIN_TDI] : 1'b1;

	// test port controller, shift paths and output timing
	always_comb
	begin
		tap_st_nxt = tap_st_r;
		ir_nxt = ir_r;
		ir_sh_nxt = ir_sh_r;
		byp_nxt = byp_r;
		tdo_nxt = tdo_r;
		tdo_en_nxt = tdo_en_r;
		if (!tap_on)
		begin
			tap_st_nxt = TAP_RESET;
			ir_nxt = IR_RST;
			tdo_en_nxt = 1'b0;
		end
		else if (tck_rise)
		begin
			case (tap_st_r)
				TAP_CAP_IR: ir_sh_nxt = IR_CAPTURE;
				TAP_SHIFT_IR: ir_sh_nxt = {tdi_v, ir_sh_r[IR_W-1:1]};
				TAP_UPD_IR: ir_nxt = ir_sh_r;
				TAP_CAP_DR: byp_nxt = 1'b0;
				TAP_SHIFT_DR: byp_nxt = tdi_v;
				TAP_RESET: ir_nxt = IR_RST;
				default: byp_nxt = byp_r;
			endcase
			case (tap_st_r)
				TAP_RESET: tap_st_nxt = tms_v ? TAP_RESET : TAP_IDLE;
				TAP_IDLE: tap_st_nxt = tms_v ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_DR: tap_st_nxt = tms_v ? TAP_SEL_IR : TAP_CAP_DR;
				TAP_CAP_DR: tap_st_nxt = tms_v ? TAP_EXIT1_DR : TAP_SHIFT_DR;
				TAP_SHIFT_DR: tap_st_nxt = tms_v ? TAP_EXIT1_DR : TAP_SHIFT_DR;
				TAP_EXIT1_DR: tap_st_nxt = tms_v ? TAP_UPD_DR : TAP_PAUSE_DR;
				TAP_PAUSE_DR: tap_st_nxt = tms_v ? TAP_EXIT2_DR : TAP_PAUSE_DR;
				TAP_EXIT2_DR: tap_st_nxt = tms_v ? TAP_UPD_DR : TAP_SHIFT_DR;
				TAP_UPD_DR: tap_st_nxt = tms_v ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_IR: tap_st_nxt = tms_v ? TAP_RESET : TAP_CAP_IR;
				TAP_CAP_IR: tap_st_nxt = tms_v ? TAP_EXIT1_IR : TAP_SHIFT_IR;
				TAP_SHIFT_IR: tap_st_nxt = tms_v ? TAP_EXIT1_IR : TAP_SHIFT_IR;
				TAP_EXIT1_IR: tap_st_nxt = tms_v ? TAP_UPD_IR : TAP_PAUSE_IR;
				TAP_PAUSE_IR: tap_st_nxt = tms_v ? TAP_EXIT2_IR : TAP_PAUSE_IR;
				TAP_EXIT2_IR: tap_st_nxt = tms_v ? TAP_UPD_IR : TAP_SHIFT_IR;
				TAP_UPD_IR: tap_st_nxt = tms_v ? TAP_SEL_DR : TAP_IDLE;
				default: tap_st_nxt = TAP_RESET;
			endcase
		end
		else if (tck_fall)
		begin
			// output and its enable change on the falling edge
			tdo_en_nxt = (tap_st_r == TAP_SHIFT_IR)
				|| (tap_st_r == TAP_SHIFT_DR);
			tdo_nxt = (tap_st_r == TAP_SHIFT_IR) ? ir_sh_r[0] : byp_r;
		end
		// reset state flag kept in a flop for the status output
		tap_rst_nxt = (tap_st_nxt == TAP_RESET);
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			tap_st_r <= TAP_RESET;
			tap_rst_r <= 1'b1;
			ir_r <= IR_RST;
			ir_sh_r <= IR_RST;
			byp_r <= 1'b0;
			tdo_r <= 1'b0;
			tdo_en_r <= 1'b0;
		end
		else
		begin
			tap_st_r <= tap_st_nxt;
			tap_rst_r <= tap_rst_nxt;
			ir_r <= ir_nxt;
			ir_sh_r <= ir_sh_nxt;
			byp_r <= byp_nxt;
			tdo_r <= tdo_nxt;
			tdo_en_r <= tdo_en_nxt;
		end
	end

	// pad drivers, one per pin; only test output has a digital alternate
	for (genvar g = 0; g < NPINS; g++)
	begin : g_cell
		cdpm_pin_cell u_cell (
			.clk_in(clk_in),
			.rstn_in(rstn_in),
			.func_in(func_r[g*FNW +: FNW]),
			.dir_in(dir_r[g]),
			.gpio_data_in(gpio_data_in[g]),
			.alt_drive_in((g == PIN_TDO) ? tdo_en_r : 1'b0),
			.alt_data_in((g == PIN_TDO) ? tdo_r : 1'b0),
			.pad_out(pad_out[g]),
			.pad_oe_n_out(pad_oe_n_out[g])
		);
	end

	assign gpio_read_out = st_r;
	assign analog_en_out = analog_r;
	assign func_out = func_r;
	assign serial1_rx_data_out = rx_r;
	assign ext_clock_out = clk_sel_r;
	assign tap_ir_out = ir_r;
	assign tap_reset_out = tap_rst_r;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	for (genvar a = 0; a < NPINS; a++)
	begin : g_ast
		AST_GPIO_DIR: assert property (
			(fn_of(func_r, a) == FN_GPIO) |=> (pad_oe_n_out[a] == ~$past(dir_r[a])))
			else $error("port pin direction not followed");
		if (a <= PIN_D7)
		begin : g_alt
			AST_ALT_NO_DRIVE: assert property (
				(fn_of(func_r, a) != FN_GPIO) |=> pad_oe_n_out[a])
				else $error("port driver left on under alternate function");
		end
	end
	AST_PORT_C_RESET: assert property (
		!loaded_r |-> (func_r[7:0] == 8'h00))
		else $error("port c pins not general purpose after reset");
	AST_PORT_D_RESET: assert property (
		!loaded_r |-> (func_r[15:8] == 8'h00) && (dir_r == DIR_RST))
		else $error("port d pins not general purpose after reset");
	AST_TEST_RESET: assert property (
		!loaded_r |-> (func_r[23:16] == 8'h55))
		else $error("test pins not in test function after reset");
	AST_EXT_CLOCK: assert property (
		(fn_of(func_r, PIN_D5) == FN_ALT2) |=> (ext_clock_out == $past(st_r[5])))
		else $error("external clock does not follow crystal output pin");
	AST_TDI_SAMPLE: assert property (
		(tck_rise && tap_st_r == TAP_SHIFT_DR) |=> (byp_r == $past(tdi_v)))
		else $error("test data not sampled on clock rise");
	AST_TDO_TRI: assert property (
		(fn_of(func_r, PIN_TDO) == FN_TEST && !tdo_en_r) |=> pad_oe_n_out[9])
		else $error("test output driven outside shift states");
	AST_TDO_FALL: assert property (
		$changed(tdo_r) |-> $past(tck_fall))
		else $error("test output changed away from falling edge");
	AST_TMS_STEP: assert property (
		(tck_rise && tap_st_r == TAP_RESET && !tms_v) |=> tap_st_r == TAP_IDLE)
		else $error("controller ignored mode select low");
	AST_TCK_GATE: assert property (
		(tap_on && !tck_rise) |=> $stable(tap_st_r))
		else $error("controller moved without a test clock rise");
endmodule

// [cdpm_board.sv]
// board and test equipment model around the pin multiplexer
`timescale 1ns/1ps
module cdpm_board
	import cdpm_pkg::*;
(
	input wire logic clk_in,
	input wire logic [11:0] pad_out_in,
	input wire logic [11:0] pad_oe_n_in,
	output logic [11:0] pad_level_out
);
	logic [11:0] ext_en;
	logic [11:0] ext_val;
	logic float_r;
	initial
	begin
		ext_en = 12'h000;
		ext_val = 12'hFFF;
		float_r = 1'b0;
	end
	// undriven pins without pull-up wander every cycle
	always @(posedge clk_in) float_r <= ~float_r;
	// wire level: device drive, else tester, else pull-up on 6..11
	always_comb
	begin
		for (int i = 0; i < NPINS; i++)
			pad_level_out[i] = !pad_oe_n_in[i] ? pad_out_in[i] :
				ext_en[i] ? ext_val[i] : (i >= 6 ? 1'b1 : float_r);
	end
	// tester sets mode and data, then one slow test clock period
	task automatic tck_pulse(input logic tms, input logic tdi,
		output logic tdo, output logic oe_n);
		@(posedge clk_in);
		ext_val[PIN_TMS] <= tms;
		ext_val[PIN_TDI] <= tdi;
		ext_val[PIN_TCK] <= 1'b0;
		repeat (10) @(posedge clk_in);
		tdo = pad_out_in[PIN_TDO];
		oe_n = pad_oe_n_in[PIN_TDO];
		ext_val[PIN_TCK] <= 1'b1;
		repeat (10) @(posedge clk_in);
	endtask
endmodule

// [testbench.sv]
// self-checking bench for the port c/d pin multiplexer
`timescale 1ns/1ps
module testbench;
	import cdpm_pkg::*;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic cfg_load_in = 1'b0;
	logic [23:0] func_sel_in = 24'h000000;
	logic [11:0] dir_sel_in = 12'h000;
	logic [11:0] gpio_data_in = 12'h000;
	logic [11:0] pad_in, pad_out, pad_oe_n_out, gpio_read_out;
	logic [11:0] analog_en_out;
	logic [23:0] func_out;
	logic serial1_rx_data_out, ext_clock_out, tap_reset_out;
	logic [3:0] tap_ir_out;
	int failures = 0;
	int checks_done = 0;
	cdpm_top u_cdpm_top (.clk_in(clk_in), .rstn_in(rstn_in),
		.cfg_load_in(cfg_load_in), .func_sel_in(func_sel_in),
		.dir_sel_in(dir_sel_in), .gpio_data_in(gpio_data_in),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe_n_out(pad_oe_n_out),
		.gpio_read_out(gpio_read_out), .analog_en_out(analog_en_out),
		.func_out(func_out), .serial1_rx_data_out(serial1_rx_data_out),
		.ext_clock_out(ext_clock_out), .tap_ir_out(tap_ir_out),
		.tap_reset_out(tap_reset_out));
	cdpm_board u_cdpm_board (.clk_in(clk_in), .pad_out_in(pad_out),
		.pad_oe_n_in(pad_oe_n_out), .pad_level_out(pad_in));
	// 20 MHz system clock
	initial
	begin
		forever #25 clk_in = ~clk_in;
	end
	// compare one value and count
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// load function and direction, then let outputs settle
	task automatic load_cfg(input logic [23:0] f, input logic [11:0] d);
		@(posedge clk_in);
		cfg_load_in <= 1'b1;
		func_sel_in <= f;
		dir_sel_in <= d;
		@(posedge clk_in);
		cfg_load_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		check(func_out, f);
	endtask
	// reset state of functions, drivers and test controller
	task automatic test_reset_values;
		check(func_out, 24'h550000);
		check(pad_oe_n_out, 12'hFFF);
		check({tap_reset_out, tap_ir_out}, 5'h1F);
	endtask
	// every pin general purpose, mixed directions, tester on inputs
	task automatic test_gpio_dir;
		gpio_data_in <= 12'hA5A;
		u_cdpm_board.ext_val <= 12'h3C3;
		u_cdpm_board.ext_en <= 12'h30A;
		load_cfg(24'h000000, 12'hCF5);
		check(pad_oe_n_out, 12'h30A);
		check(pad_out & 12'hCF5, 12'h850);
		check(gpio_read_out, 12'hB52);
		check(tap_reset_out, 1'b1);
	endtask
	// analog function pulls the port driver off even with dir out
	task automatic test_alternates;
		u_cdpm_board.ext_en <= 12'h000;
		load_cfg(24'h555555, 12'hFFF);
		check(pad_oe_n_out[7:0], 8'hFF);
		check(analog_en_out[7:0], 8'hFF);
		u_cdpm_board.ext_en <= 12'h021;
		for (int v = 1; v >= 0; v--)
		begin
			u_cdpm_board.ext_val <= {12{v[0]}};
			load_cfg(24'h550802, 12'h000);
			check(serial1_rx_data_out, v[0]);
			check(ext_clock_out, v[0]);
			check(analog_en_out[7:0], 8'h00);
		end
	endtask
	// scan 4'hA into the instruction register, one bit through bypass
	task automatic test_tap;
		logic [19:0] tms_seq = 20'b01100000110100011111;
		logic [19:0] tdi_seq = 20'b00000010100000100000;
		logic [19:0] drv_seq = 20'b00000111100000110000;
		logic [19:0] tdo_seq = 20'b00000100000000010000;
		logic tdo, oe_n;
		u_cdpm_board.ext_en <= 12'hD00;
		u_cdpm_board.ext_val <= 12'hFFF;
		load_cfg(24'h550000, 12'h000);
		for (int i = 0; i < 20; i++)
		begin
			u_cdpm_board.tck_pulse(tms_seq[19 - i], tdi_seq[19 - i], tdo, oe_n);
			if (i == 0)
				check(tap_reset_out, 1'b0);
			check(oe_n, !drv_seq[19 - i]);
			if (drv_seq[19 - i])
				check(tdo, tdo_seq[19 - i]);
			if (i == 10)
				check(tap_ir_out, 4'hA);
		end
		check({tap_reset_out, oe_n}, 2'h3);
	endtask
	// cut a hang short
	initial
	begin
		repeat (20000) @(posedge clk_in);
		failures++;
		end_sim();
	end
	// main sequence
	initial
	begin
		repeat (4) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		test_reset_values();
		test_gpio_dir();
		test_alternates();
		test_tap();
		end_sim();
	end
endmodule
